// ===== adcrt_pkg.sv
// Package for the converter result and trigger register block
package adcrt_pkg;
	// ==========================================================
	// Register word indices, byte address is four times the index
	localparam int         ADDR_W              = 10;
	localparam logic [7:0] RESULT_LOW_ADDR     = 8'h78;
	localparam logic [7:0] RESULT_HIGH_ADDR    = 8'h79;
	localparam logic [7:0] CONTROL_B_ADDR      = 8'h7b;
	localparam logic [7:0] PIN_DISABLE_ADDR    = 8'h7e;
	localparam logic [7:0] CONTROL_A_ADDR      = 8'h80;
	localparam logic [7:0] IRQ_STATUS_ADDR     = 8'h84;
	localparam logic [7:0] IRQ_MASK_ADDR       = 8'h88;
	// ==========================================================
	// Field positions and widths
	localparam int RESULT_W          = 10;
	localparam int TRIG_SEL_W        = 3;
	localparam int PIN_COUNT         = 6;
	localparam int SOURCE_COUNT      = 8;
	localparam int CMP_MUX_BIT       = 6;
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_AUTO_BIT     = 1;
	localparam int CTRL_LEFT_BIT     = 2;
	localparam int IRQ_W             = 2;
	localparam int IRQ_DONE_BIT      = 0;
	localparam int IRQ_TRIG_BIT      = 1;
	// ==========================================================
	// Reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// ==========================================================
	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Trigger source encodings
	typedef enum logic [2:0] {
		ADCRT_FREE_RUN  = 3'h0,
		ADCRT_ANA_CMP   = 3'h1,
		ADCRT_EXT_INT0  = 3'h2,
		ADCRT_T0_CMP_A  = 3'h3,
		ADCRT_T0_OVF    = 3'h4,
		ADCRT_T1_CMP_B  = 3'h5,
		ADCRT_T1_OVF    = 3'h6,
		ADCRT_T1_CAPT   = 3'h7
	} adcrt_trig_t;
	// ==========================================================
	// Converter result carrier
	typedef struct packed {
		logic                valid;
		logic [RESULT_W-1:0] data;
	} adcrt_result_t;
endpackage : adcrt_pkg

// ===== adcrt_regs.sv
// Result, trigger and pin input disable registers on AXI4-Lite
// Notes on behaviour
// RULE_01 - Completed unlocked conversion loads the 10-bit result into result bytes.
// RULE_02 - Right adjust: high byte holds bits 9:8, low byte bits 7:0.
// RULE_03 - Left adjust: high byte bits 9:2, low byte bits 7:6 hold 1:0.
// RULE_04 - Reading low byte locks result until the high byte is read.
// RULE_05 - Software reads low byte first; high alone suffices if left adjusted.
// RULE_06 - Both result bytes are read-only and reset to zero.
// RULE_07 - Trigger source only acts when auto trigger is enabled.
// RULE_08 - Auto conversion starts on rising edge of selected flag.
// RULE_09 - Switching selection from clear to set flag gives a trigger edge.
// RULE_10 - Selecting free running never itself produces a trigger event.
// RULE_11 - Trigger source encoding follows the fixed eight-entry table.
// RULE_12 - Software writes zero to control bits 7 and 5:3; they read zero.
// RULE_13 - Set disable bit turns off pin input buffer; pin reads zero.
// RULE_14 - Software writes zero to pin disable bits 7:6.
// RULE_15 - Software should disable inputs of analog-only pins to save power.
// RULE_16 - Channels 6 and 7 have no input buffer and no disable bit.
// RULE_17 - Left adjust change alters result presentation at once.
// RULE_18 - With auto trigger set, a positive selected edge starts conversion.
// RULE_19 - Conversion finishing while locked does not overwrite the result.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module adcrt_regs #(
	parameter int PIN_COUNT = adcrt_pkg::PIN_COUNT
) (
	// Clock and reset
	input  wire logic                    CLOCK_IN,
	input  wire logic                    SRST_IN,
	// AXI4-Lite write address and data
	input  wire logic                    AWVALID_IN,
	output logic                         AWREADY_OUT,
	input  wire logic [adcrt_pkg::ADDR_W-1:0] AWADDR_IN,
	input  wire logic                    WVALID_IN,
	output logic                         WREADY_OUT,
	input  wire logic [31:0]             WDATA_IN,
	input  wire logic [3:0]              WSTRB_IN,
	// AXI4-Lite write response
	output logic                         BVALID_OUT,
	input  wire logic                    BREADY_IN,
	output logic [1:0]                   BRESP_OUT,
	// AXI4-Lite read
	input  wire logic                    ARVALID_IN,
	output logic                         ARREADY_OUT,
	input  wire logic [adcrt_pkg::ADDR_W-1:0] ARADDR_IN,
	output logic                         RVALID_OUT,
	input  wire logic                    RREADY_IN,
	output logic [31:0]                  RDATA_OUT,
	output logic [1:0]                   RRESP_OUT,
	// Conversion engine
	input  wire adcrt_pkg::adcrt_result_t RESULT_IN,
	input  wire logic                    BUSY_IN,
	output logic                         START_OUT,
	output logic                         ENABLE_OUT,
	output logic                         CMP_MUX_ENABLE_OUT,
	// Peripheral event flags, index by trigger source
	input  wire logic [7:0]              EVENT_FLAGS_IN,
	// Analog pins
	input  wire logic [PIN_COUNT-1:0]    PIN_RAW_IN,
	output logic [PIN_COUNT-1:0]         PIN_VALUE_OUT,
	output logic [PIN_COUNT-1:0]         PIN_BUFFER_ENABLE_OUT,
	// Interrupt
	output logic                         IRQ_OUT
);
	// ==========================================================
	// State
	logic [9:0]            result;
	logic                  locked;
	logic [2:0]            trig_sel;
	logic                  cmp_mux;
	logic [PIN_COUNT-1:0]  pin_dis;
	logic [2:0]            ctrl;
	logic [1:0]            irq_stat;
	logic [1:0]            irq_mask;
	logic                  trig_prev;
	logic                  aw_held;
	logic                  w_held;
	logic [7:0]            aw_addr;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic                  bvalid;
	logic [1:0]            bresp;
	logic                  rvalid;
	logic [31:0]           rdata;
	logic [1:0]            rresp;
	logic                  start;
	logic [PIN_COUNT-1:0]  pin_s1;
	logic [PIN_COUNT-1:0]  pin_s2;
	logic [PIN_COUNT-1:0]  pin_val;
	logic [9:0]            next_result;
	logic                  next_locked;
	logic [2:0]            next_trig_sel;
	logic                  next_cmp_mux;
	logic [PIN_COUNT-1:0]  next_pin_dis;
	logic [2:0]            next_ctrl;
	logic [1:0]            next_irq_stat;
	logic [1:0]            next_irq_mask;
	logic                  next_trig_prev;
	logic                  next_aw_held;
	logic                  next_w_held;
	logic [7:0]            next_aw_addr;
	logic [31:0]           next_w_data;
	logic [3:0]            next_w_strb;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic                  next_rvalid;
	logic [31:0]           next_rdata;
	logic [1:0]            next_rresp;
	logic                  next_start;
	logic [PIN_COUNT-1:0]  next_pin_val;
	// ==========================================================
	// Combinational helpers
	logic       do_write;
	logic       do_read;
	logic       trig_level;
	logic       trig_edge;
	logic [7:0] low_byte;
	logic [7:0] high_byte;
	logic       left;
	always_comb begin
		left = ctrl[adcrt_pkg::CTRL_LEFT_BIT];
		if (left) begin                                              // [RULE_03] [RULE_17]
			high_byte = result[9:2];
			low_byte  = {result[1:0], 6'h00};
		end else begin                                               // [RULE_02]
			high_byte = {6'h00, result[9:8]};
			low_byte  = result[7:0];
		end
		// Free running selects no flag, so no edge can appear
		if (adcrt_pkg::adcrt_trig_t'(trig_sel) == adcrt_pkg::ADCRT_FREE_RUN) begin
			trig_level = 1'b0;                                       // [RULE_10]
		end else begin
			trig_level = EVENT_FLAGS_IN[trig_sel];                   // [RULE_11] [RULE_09]
		end
		trig_edge = trig_level && !trig_prev;                        // [RULE_08]
		do_write  = aw_held && w_held && !bvalid;
		do_read   = ARVALID_IN && !rvalid;
	end
	// ==========================================================
	// Next state
	always_comb begin
		next_result    = result;
		next_locked    = locked;
		next_trig_sel  = trig_sel;
		next_cmp_mux   = cmp_mux;
		next_pin_dis   = pin_dis;
		next_ctrl      = ctrl;
		next_irq_stat  = irq_stat;
		next_irq_mask  = irq_mask;
		next_trig_prev = trig_level;
		next_aw_held   = aw_held;
		next_w_held    = w_held;
		next_aw_addr   = aw_addr;
		next_w_data    = w_data;
		next_w_strb    = w_strb;
		next_bvalid    = bvalid && !BREADY_IN;
		next_bresp     = bresp;
		next_rvalid    = rvalid && !RREADY_IN;
		next_rdata     = rdata;
		next_rresp     = rresp;
		next_start     = 1'b0;
		next_pin_val   = pin_s2 & ~pin_dis;                          // [RULE_13]
		if (AWVALID_IN && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = AWADDR_IN[adcrt_pkg::ADDR_W-1:2];
		end
		if (WVALID_IN && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = WDATA_IN;
			next_w_strb = WSTRB_IN;
		end
		// Write completion
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = adcrt_pkg::RESP_OKAY;
			if (w_strb[0]) begin
				case (aw_addr)
					adcrt_pkg::CONTROL_B_ADDR: begin
						next_trig_sel = w_data[2:0];                 // [RULE_12]
						next_cmp_mux  = w_data[adcrt_pkg::CMP_MUX_BIT];
					end
					adcrt_pkg::PIN_DISABLE_ADDR: begin
						next_pin_dis = w_data[PIN_COUNT-1:0];        // [RULE_16]
					end
					adcrt_pkg::CONTROL_A_ADDR: begin
						next_ctrl = w_data[2:0];
					end
					adcrt_pkg::IRQ_MASK_ADDR: begin
						next_irq_mask = w_data[1:0];
					end
					adcrt_pkg::IRQ_STATUS_ADDR: begin
						next_irq_stat = irq_stat & ~w_data[1:0];
					end
					adcrt_pkg::RESULT_LOW_ADDR,
					adcrt_pkg::RESULT_HIGH_ADDR: begin
						next_bresp = adcrt_pkg::RESP_SLVERR;         // [RULE_06]
					end
					default: begin
						next_bresp = adcrt_pkg::RESP_SLVERR;
					end
				endcase
			end else if (aw_addr != adcrt_pkg::CONTROL_B_ADDR
					&& aw_addr != adcrt_pkg::PIN_DISABLE_ADDR
					&& aw_addr != adcrt_pkg::CONTROL_A_ADDR
					&& aw_addr != adcrt_pkg::IRQ_MASK_ADDR
					&& aw_addr != adcrt_pkg::IRQ_STATUS_ADDR) begin
				next_bresp = adcrt_pkg::RESP_SLVERR;
			end
		end
		// Read
		if (do_read) begin
			next_rvalid = 1'b1;
			next_rresp  = adcrt_pkg::RESP_OKAY;
			case (ARADDR_IN[adcrt_pkg::ADDR_W-1:2])
				adcrt_pkg::RESULT_LOW_ADDR: begin
					next_rdata  = {24'h000000, low_byte};
					next_locked = 1'b1;                              // [RULE_04]
				end
				adcrt_pkg::RESULT_HIGH_ADDR: begin
					next_rdata  = {24'h000000, high_byte};
					next_locked = 1'b0;                              // [RULE_04]
				end
				adcrt_pkg::CONTROL_B_ADDR: begin
					next_rdata = {24'h000000, 1'b0, cmp_mux, 3'h0, trig_sel};
				end
				adcrt_pkg::PIN_DISABLE_ADDR: begin
					next_rdata = {{(32 - PIN_COUNT){1'b0}}, pin_dis};
				end
				adcrt_pkg::CONTROL_A_ADDR: begin
					next_rdata = {28'h0000000, BUSY_IN, ctrl};
				end
				adcrt_pkg::IRQ_STATUS_ADDR: begin
					next_rdata = {30'h00000000, irq_stat};
				end
				adcrt_pkg::IRQ_MASK_ADDR: begin
					next_rdata = {30'h00000000, irq_mask};
				end
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = adcrt_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Result capture, skipped while locked
		// A low byte read in the same cycle locks first
		if (RESULT_IN.valid && !locked && !next_locked) begin        // [RULE_19]
			next_result = RESULT_IN.data;                            // [RULE_01]
		end
		if (RESULT_IN.valid) begin
			next_irq_stat[adcrt_pkg::IRQ_DONE_BIT] = 1'b1;           // [RULE_19]
		end
		// Auto trigger
		if (ctrl[adcrt_pkg::CTRL_AUTO_BIT] && ctrl[adcrt_pkg::CTRL_ENABLE_BIT]
				&& trig_edge) begin
			next_start = 1'b1;                                       // [RULE_07] [RULE_18]
			next_irq_stat[adcrt_pkg::IRQ_TRIG_BIT] = 1'b1;
		end
	end
	// ==========================================================
	// Registers
	always_ff @(posedge CLOCK_IN) begin
		pin_s1 <= PIN_RAW_IN;
		pin_s2 <= pin_s1;
		if (SRST_IN) begin
			result    <= 10'h000;                                    // [RULE_06]
			locked    <= 1'b0;
			trig_sel  <= adcrt_pkg::BYTE_RESET[2:0];
			cmp_mux   <= 1'b0;
			pin_dis   <= '0;
			ctrl      <= 3'h0;
			irq_stat  <= 2'h0;
			irq_mask  <= 2'h0;
			trig_prev <= 1'b0;
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h00000000;
			w_strb    <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= 2'h0;
			rvalid    <= 1'b0;
			rdata     <= 32'h00000000;
			rresp     <= 2'h0;
			start     <= 1'b0;
			pin_val   <= '0;
		end else begin
			result    <= next_result;
			locked    <= next_locked;
			trig_sel  <= next_trig_sel;
			cmp_mux   <= next_cmp_mux;
			pin_dis   <= next_pin_dis;
			ctrl      <= next_ctrl;
			irq_stat  <= next_irq_stat;
			irq_mask  <= next_irq_mask;
			trig_prev <= next_trig_prev;
			aw_held   <= next_aw_held;
			w_held    <= next_w_held;
			aw_addr   <= next_aw_addr;
			w_data    <= next_w_data;
			w_strb    <= next_w_strb;
			bvalid    <= next_bvalid;
			bresp     <= next_bresp;
			rvalid    <= next_rvalid;
			rdata     <= next_rdata;
			rresp     <= next_rresp;
			start     <= next_start;
			pin_val   <= next_pin_val;
		end
	end
	// ==========================================================
	// Outputs
	assign AWREADY_OUT           = !aw_held;
	assign WREADY_OUT            = !w_held;
	assign BVALID_OUT            = bvalid;
	assign BRESP_OUT             = bresp;
	assign ARREADY_OUT           = !rvalid;
	assign RVALID_OUT            = rvalid;
	assign RDATA_OUT             = rdata;
	assign RRESP_OUT             = rresp;
	assign START_OUT             = start;
	assign ENABLE_OUT            = ctrl[adcrt_pkg::CTRL_ENABLE_BIT];
	assign CMP_MUX_ENABLE_OUT    = cmp_mux;
	assign PIN_VALUE_OUT         = pin_val;
	assign PIN_BUFFER_ENABLE_OUT = ~pin_dis;                         // [RULE_13]
	assign IRQ_OUT               = |(irq_stat & irq_mask);
endmodule : adcrt_regs

// ===== adcrt_regs_checker.sv
// Assertion checker for the converter register block
`timescale 1ns/1ns
module adcrt_regs_checker #(
	parameter int PIN_COUNT = 6
) (
	// Clock and reset
	input wire logic                 CLOCK_IN,
	input wire logic                 SRST_IN,
	// Register bus
	input wire logic                 AWVALID_IN,
	input wire logic                 AWREADY_OUT,
	input wire logic                 WVALID_IN,
	input wire logic                 WREADY_OUT,
	input wire logic                 BVALID_OUT,
	input wire logic                 ARVALID_IN,
	input wire logic                 ARREADY_OUT,
	input wire logic                 RVALID_OUT,
	input wire logic                 RREADY_IN,
	input wire logic [31:0]          RDATA_OUT,
	// Trigger and pins
	input wire logic                 START_OUT,
	input wire logic                 ENABLE_OUT,
	input wire logic [7:0]           EVENT_FLAGS_IN,
	input wire logic [PIN_COUNT-1:0] PIN_RAW_IN,
	input wire logic [PIN_COUNT-1:0] PIN_VALUE_OUT,
	input wire logic [PIN_COUNT-1:0] PIN_BUFFER_ENABLE_OUT
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (SRST_IN);
	start_pulse_a: assert property (START_OUT |=> !START_OUT)
		else $error("start pulse longer than one cycle");
	start_enabled_a: assert property (START_OUT |-> $past(ENABLE_OUT))
		else $error("start while converter disabled");
	start_cause_a: assert property (START_OUT |->
		(($past(EVENT_FLAGS_IN) | $past(EVENT_FLAGS_IN, 2)) & 8'hfe) != 8'h00)
		else $error("start without any raised flag");
	pin_blocked_a: assert property (
		(PIN_VALUE_OUT & ~PIN_BUFFER_ENABLE_OUT & ~$past(PIN_BUFFER_ENABLE_OUT)) == '0)
		else $error("disabled pin reads nonzero");
	pin_follow_a: assert property (($stable(PIN_RAW_IN) && $stable(PIN_BUFFER_ENABLE_OUT))[*4]
		|-> PIN_VALUE_OUT == (PIN_RAW_IN & PIN_BUFFER_ENABLE_OUT))
		else $error("enabled pin value does not follow input");
	write_resp_a: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT
		|-> ##[1:2] BVALID_OUT) else $error("write response missing");
	read_resp_a: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
		else $error("read response missing");
	rdata_hold_a: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
		else $error("read data dropped before ready");
	reset_state_a: assert property (disable iff (1'b0) SRST_IN |=>
		!START_OUT && !RVALID_OUT && !BVALID_OUT && PIN_BUFFER_ENABLE_OUT == '1)
		else $error("wrong state after reset");
endmodule : adcrt_regs_checker
bind adcrt_regs adcrt_regs_checker #(.PIN_COUNT(PIN_COUNT)) adcrt_regs_checker_inst (
	.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .AWVALID_IN(AWVALID_IN),
	.AWREADY_OUT(AWREADY_OUT), .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT),
	.BVALID_OUT(BVALID_OUT), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
	.RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .RDATA_OUT(RDATA_OUT),
	.START_OUT(START_OUT), .ENABLE_OUT(ENABLE_OUT), .EVENT_FLAGS_IN(EVENT_FLAGS_IN),
	.PIN_RAW_IN(PIN_RAW_IN), .PIN_VALUE_OUT(PIN_VALUE_OUT),
	.PIN_BUFFER_ENABLE_OUT(PIN_BUFFER_ENABLE_OUT)
);

// ===== adcrt_conv_model.sv
// Behavioural conversion engine answering start requests
`timescale 1ns/1ns
module adcrt_conv_model (
	// Clock and reset
	input  wire logic                clock_in,
	input  wire logic                srst_in,
	// Start request, value and latency
	input  wire logic                start_in,
	input  wire logic [9:0]          value_in,
	input  wire logic [3:0]          delay_in,
	// Result towards the registers
	output adcrt_pkg::adcrt_result_t result_out,
	output logic                     busy_out
);
	logic [3:0] count;
	logic [3:0] next_count;
	logic [9:0] held;
	logic [9:0] next_held;
	always_comb begin
		next_count = count;
		next_held  = held;
		if (count != 4'h0) begin
			next_count = count - 4'h1;
		end else if (start_in) begin
			next_count = delay_in + 4'h1;
			next_held  = value_in;
		end
	end
	always_ff @(posedge clock_in) begin
		count <= srst_in ? 4'h0 : next_count;
		held  <= srst_in ? 10'h000 : next_held;
	end
	// Data shows the inverse outside the valid cycle
	assign busy_out   = count != 4'h0;
	assign result_out = {count == 4'h1, (count == 4'h1) ? held : ~held};
endmodule : adcrt_conv_model

// ===== test_adc_result_and_trigger_regs.sv
// Self-checking bench for the converter result and trigger registers
`timescale 1ns/1ns
module test_adc_result_and_trigger_regs;
	logic clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0;
	logic arv = 1'b0, rready = 1'b0, go = 1'b0;
	logic [7:0] flags = 8'h00, b;
	logic [9:0] awa = 10'h000, ara = 10'h000;
	logic [31:0] wd = 32'h0, rdat;
	logic [5:0] raw = 6'h00, pv, pbe;
	logic [9:0] cv = 10'h000, v;
	logic [3:0] dly = 4'h0;
	logic [1:0] bresp, rresp;
	logic awr, wrdy, bv, arr, rv, st, en, cme, irq, busy;
	adcrt_pkg::adcrt_result_t res;
	int fails = 0, checked = 0, starts = 0, n;
	adcrt_regs adcrt_regs_inst (
		.CLOCK_IN(clk), .SRST_IN(srst), .AWVALID_IN(awv), .AWREADY_OUT(awr),
		.AWADDR_IN(awa), .WVALID_IN(wv), .WREADY_OUT(wrdy), .WDATA_IN(wd), .WSTRB_IN(4'hf),
		.BVALID_OUT(bv), .BREADY_IN(bready), .BRESP_OUT(bresp), .ARVALID_IN(arv),
		.ARREADY_OUT(arr), .ARADDR_IN(ara), .RVALID_OUT(rv), .RREADY_IN(rready),
		.RDATA_OUT(rdat), .RRESP_OUT(rresp), .RESULT_IN(res), .BUSY_IN(busy),
		.START_OUT(st), .ENABLE_OUT(en), .CMP_MUX_ENABLE_OUT(cme), .EVENT_FLAGS_IN(flags),
		.PIN_RAW_IN(raw), .PIN_VALUE_OUT(pv), .PIN_BUFFER_ENABLE_OUT(pbe), .IRQ_OUT(irq));
	adcrt_conv_model adcrt_conv_model_inst (.clock_in(clk), .srst_in(srst),
		.start_in(st | go), .value_in(cv), .delay_in(dly), .result_out(res), .busy_out(busy));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (st === 1'b1) starts++;
	end
	function automatic logic [7:0] lo(input logic [9:0] x, input logic l);
		return l ? {x[1:0], 6'h00} : x[7:0];
	endfunction : lo
	function automatic logic [7:0] hi(input logic [9:0] x, input logic l);
		return l ? x[9:2] : {6'h00, x[9:8]};
	endfunction : hi
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
			fails++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		awv <= 1'b1;
		awa <= {a, 2'h0};
		wv <= 1'b1;
		wd <= {24'h0, d};
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (!bv);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge clk);
		arv <= 1'b1;
		ara <= {a, 2'h0};
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rready <= 1'b0;
		chk(rdat, {24'h0, e});
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rdc
	task automatic conv(input logic [9:0] x);
		cv <= x;
		dly <= 4'($urandom % 15);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do begin
			@(posedge clk);
		end while (!res.valid);
		@(posedge clk);
	endtask : conv
	task automatic conclude();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		n = $urandom(32'h3c25);
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rdc(8'h78, 8'h00, 2'h0);
		rdc(8'h79, 8'h00, 2'h0);
		wr(8'h79, 8'h5a, 2'h2);
		rdc(8'h90, 8'h00, 2'h2);
		for (int i = 0; i < 6; i++) begin
			v = (i < 2) ? {10{i[0]}} : 10'($urandom);
			conv(v);
			wr(8'h80, {5'h0, i[0], 2'h0}, 2'h0);
			rdc(8'h78, lo(v, i[0]), 2'h0);
			conv(v ^ 10'h2a5);
			wr(8'h80, {5'h0, !i[0], 2'h0}, 2'h0);
			rdc(8'h79, hi(v, !i[0]), 2'h0);
		end
		for (int i = 0; i < 4; i++) begin
			b = 8'($urandom) & 8'h47;
			wr(8'h7b, b, 2'h0);
			rdc(8'h7b, b, 2'h0);
			chk({cme}, {b[6]});
			b = (i == 0) ? 8'h3f : 8'($urandom) & 8'h3f;
			wr(8'h7e, b, 2'h0);
			raw <= 6'($urandom);
			repeat (5) @(posedge clk);
			chk({pv}, {raw & ~b[5:0]});
			chk({pbe}, {~b[5:0]});
		end
		wr(8'h80, 8'h03, 2'h0);
		chk({en}, 1'b1);
		for (int s = 1; s < 8; s++) begin
			wr(8'h7b, 8'(s), 2'h0);
			n = starts;
			flags[s] <= 1'b1;
			repeat (8) @(posedge clk);
			flags <= 8'h00;
			chk(starts - n, 1);
		end
		wr(8'h7b, 8'h01, 2'h0);
		flags <= 8'h04;
		n = starts;
		wr(8'h7b, 8'h02, 2'h0);
		repeat (4) @(posedge clk);
		chk(starts - n, 1);
		flags <= 8'hff;
		wr(8'h7b, 8'h00, 2'h0);
		wr(8'h80, 8'h01, 2'h0);
		wr(8'h7b, 8'h03, 2'h0);
		flags <= 8'h00;
		repeat (2) @(posedge clk);
		flags <= 8'h08;
		repeat (4) @(posedge clk);
		chk(starts - n, 1);
		rdc(8'h84, 8'h03, 2'h0);
		wr(8'h84, 8'h03, 2'h0);
		wr(8'h88, 8'h01, 2'h0);
		rdc(8'h80, 8'h01, 2'h0);
		conv(10'h155);
		repeat (2) @(posedge clk);
		chk({irq}, 1'b1);
		wr(8'h88, 8'h00, 2'h0);
		repeat (2) @(posedge clk);
		chk({irq}, 1'b0);
		wr(8'h88, 8'h01, 2'h0);
		wr(8'h84, 8'h01, 2'h0);
		repeat (2) @(posedge clk);
		chk({irq}, 1'b0);
		conclude();
	end
endmodule : test_adc_result_and_trigger_regs
